// ==== design/dps_ctrl.sv ====
// Function
// (R1) Keep clock enable high until mode-register delays pass after the last MRS.
// (R2) Device acts on previous and current clock-enable samples with state.
// (R3) Device ignores command pins while clock enable stays low.
// (R4) Power-down entry and exit edges carry only NOP.
// (R5) Self refresh exit edge carries only NOP.
// (R6) Self refresh entry only from all-banks-idle, REFRESH with clock enable falling.
// (R7) Never enter self refresh while a read or write burst runs.
// (R8) Power-down becomes active or precharge kind by bank state.
// (R9) Falling clock enable with NOP while idle gives precharge power-down.
// (R10) Idle means banks closed, no burst, clock enable high, timings met.
// (R11) No refresh in power-down; leave it in time for refresh.
// (R12) Hold each new clock-enable level for the minimum pulse time.
// (R13) Only NOP during self refresh exit delay; reads and termination after DLL lock.
// (R14) No write or write leveling before 512 clocks after self refresh exit.
// (R15) Termination off throughout self refresh.
// (R16) Issue only legal commands and sequences.
// (R17) Device decodes commands from the strobes and clock enable at rising edge.
// (R18) DESELECT acts like NOP.
// (R19) Device leaves self refresh asynchronously when clock enable rises.
// (R20) Keep previous clock-enable copy and a power state register.
`timescale 1ns/1ps
`default_nettype none
`include "dps_defs.svh"

module dps_ctrl
    import dps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire dps_cmd_type req_cmd,
    output logic req_ready,
    input wire logic odt_req,
    output dps_state_type pwr_state,
    output logic ddr_cke,
    output logic ddr_cs_n,
    output logic ddr_ras_n,
    output logic ddr_cas_n,
    output logic ddr_we_n,
    output logic ddr_odt
);

    localparam int TMRS = `DPS_TMRS_NCK;
    localparam int TCKE = `DPS_TCKE_NCK;
    localparam int TXS = `DPS_TXS_NCK;
    localparam int TXSDLL = `DPS_TXSDLL_NCK;
    localparam int TWRL = `DPS_TWRLVL_NCK;
    localparam int PDMAX = `DPS_PD_MAX_NCK;

    dps_tmr_if tif ();

    genvar gi;
    generate
        for (gi = 0; gi < `DPS_NT; gi = gi + 1) begin : g_tmr
            dps_timer #(.IDX(gi)) u_tmr (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .t(tif.timer)
            );
        end
    endgenerate

    dps_state_type state_q, state_d;
    logic cke_q, cke_d;
    logic [3:0] pin_q, pin_d;
    logic odt_q, odt_d;
    logic open_q, open_d;
    logic [`DPS_NT-1:0] ld;
    logic [`DPS_NT-1:0][`DPS_TW-1:0] ldv;
    logic in_pd, in_up, auto_pdx, fire;
    logic b_mrs, b_cke, b_bst, b_xs, b_dll, b_wrl, b_pd;

    assign b_mrs = tif.busy[`DPS_T_MRS];
    assign b_cke = tif.busy[`DPS_T_CKE];
    assign b_bst = tif.busy[`DPS_T_BST];
    assign b_xs = tif.busy[`DPS_T_XS];
    assign b_dll = tif.busy[`DPS_T_DLL];
    assign b_wrl = tif.busy[`DPS_T_WRL];
    assign b_pd = tif.busy[`DPS_T_PD];
    assign tif.load = ld;
    assign tif.val = ldv;

    assign in_pd = (state_q == ST_APD) || (state_q == ST_PPD);
    assign in_up = (state_q == ST_IDLE) || (state_q == ST_ACTIVE);
    // Forced exit wins over any request; refresh is the caller's job [R11]
    assign auto_pdx = in_pd && !b_pd && !b_cke;
    assign fire = req_valid && req_ready;

    // ----------------------------------------
    // Legality of the offered request
    // ----------------------------------------
    always_comb begin
        req_ready = 1'b0;
        if (!auto_pdx) begin
            case (req_cmd)
                CMD_NOP: req_ready = 1'b1;
                CMD_MRS: req_ready = (state_q == ST_IDLE) && !b_xs && !b_mrs; // [R16]
                CMD_REF: req_ready = (state_q == ST_IDLE) && !b_xs && !b_bst && !b_mrs;
                CMD_ACT: req_ready = in_up && !b_xs && !b_mrs;
                CMD_PRE: req_ready = in_up && !b_xs && !b_bst;
                CMD_RD: req_ready = (state_q == ST_ACTIVE) && !b_xs && !b_dll && !b_bst; // [R13]
                CMD_WR: req_ready = (state_q == ST_ACTIVE) && !b_xs && !b_wrl && !b_bst; // [R14]
                // Entry held off until the mode-register delays pass [R1] [R12]
                CMD_PDE: req_ready = in_up && !b_mrs && !b_cke && !b_bst && !b_xs;
                // Idle only: banks closed, no burst, timings met [R6] [R7] [R10]
                CMD_SRE: req_ready = (state_q == ST_IDLE) && !b_mrs && !b_cke && !b_bst && !b_xs;
                CMD_PDX: req_ready = in_pd && !b_cke; // [R12]
                CMD_SRX: req_ready = (state_q == ST_SREF) && !b_cke; // [R12]
                default: req_ready = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // Power state, pins and timer loads
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        cke_d = cke_q;
        pin_d = `DPS_PIN_NOP; // [R3] [R4] [R5] [R18]
        open_d = open_q;
        ld = '0;
        ldv = '0;
        if (auto_pdx || (fire && req_cmd == CMD_PDX)) begin
            cke_d = 1'b1; // [R4]
            state_d = open_q ? ST_ACTIVE : ST_IDLE;
            ld[`DPS_T_CKE] = 1'b1;
            ldv[`DPS_T_CKE] = dps_cnt_type'(`DPS_TCKE_NCK - 1);
            ld[`DPS_T_XS] = 1'b1;
            ldv[`DPS_T_XS] = dps_cnt_type'(`DPS_TXP_NCK - 1);
        end else if (fire) begin
            case (req_cmd)
                CMD_MRS: begin
                    pin_d = `DPS_PIN_MRS;
                    ld[`DPS_T_MRS] = 1'b1; // [R1]
                    ldv[`DPS_T_MRS] = dps_cnt_type'(`DPS_TMRS_NCK - 1);
                end
                CMD_REF: pin_d = `DPS_PIN_REF;
                CMD_ACT: begin
                    pin_d = `DPS_PIN_ACT;
                    open_d = 1'b1;
                    state_d = ST_ACTIVE;
                end
                CMD_PRE: begin
                    // Treated as closing every bank; no per-bank tracking
                    pin_d = `DPS_PIN_PRE;
                    open_d = 1'b0;
                    state_d = ST_IDLE;
                end
                CMD_RD, CMD_WR: begin
                    pin_d = (req_cmd == CMD_RD) ? `DPS_PIN_RD : `DPS_PIN_WR;
                    ld[`DPS_T_BST] = 1'b1;
                    ldv[`DPS_T_BST] = dps_cnt_type'(`DPS_TBURST_NCK - 1);
                end
                CMD_PDE: begin
                    cke_d = 1'b0; // [R4]
                    state_d = open_q ? ST_APD : ST_PPD; // [R8] [R9] [R20]
                    ld[`DPS_T_CKE] = 1'b1;
                    ldv[`DPS_T_CKE] = dps_cnt_type'(`DPS_TCKE_NCK - 1);
                    ld[`DPS_T_PD] = 1'b1;
                    ldv[`DPS_T_PD] = dps_cnt_type'(`DPS_PD_MAX_NCK - 1);
                end
                CMD_SRE: begin
                    cke_d = 1'b0;
                    pin_d = `DPS_PIN_REF; // [R6]
                    state_d = ST_SREF;
                    ld[`DPS_T_CKE] = 1'b1;
                    ldv[`DPS_T_CKE] = dps_cnt_type'(`DPS_TCKE_NCK - 1);
                end
                CMD_SRX: begin
                    cke_d = 1'b1; // [R5] [R19]
                    state_d = ST_IDLE;
                    ld[`DPS_T_CKE] = 1'b1;
                    ldv[`DPS_T_CKE] = dps_cnt_type'(`DPS_TCKE_NCK - 1);
                    ld[`DPS_T_XS] = 1'b1; // [R13]
                    ldv[`DPS_T_XS] = dps_cnt_type'(`DPS_TXS_NCK - 1);
                    ld[`DPS_T_DLL] = 1'b1;
                    ldv[`DPS_T_DLL] = dps_cnt_type'(`DPS_TXSDLL_NCK - 1);
                    ld[`DPS_T_WRL] = 1'b1; // [R14]
                    ldv[`DPS_T_WRL] = dps_cnt_type'(`DPS_TWRLVL_NCK - 1);
                end
                default: pin_d = `DPS_PIN_NOP;
            endcase
        end
        // Termination only when up and DLL locked, exit edge included [R13] [R15]
        odt_d = odt_req && (state_d inside {ST_IDLE, ST_ACTIVE}) && !b_dll && !ld[`DPS_T_DLL];
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            cke_q <= 1'b1;
            pin_q <= `DPS_PIN_NOP;
            odt_q <= 1'b0;
            open_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cke_q <= cke_d; // [R2] [R20]
            pin_q <= pin_d;
            odt_q <= odt_d;
            open_q <= open_d;
        end
    end

    assign pwr_state = state_q;
    assign ddr_cke = cke_q;
    assign {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} = pin_q; // [R17]
    assign ddr_odt = odt_q;

    // ----------------------------------------
    // Checking helpers: clocks since events
    // ----------------------------------------
    dps_cnt_type s_mrs_q, s_mrs_d, s_cke_q, s_cke_d, s_srx_q, s_srx_d;
    logic cke_chg;

    assign cke_chg = (cke_d != cke_q);

    always_comb begin
        s_mrs_d = (s_mrs_q == `DPS_CNT_SAT) ? s_mrs_q : s_mrs_q + `DPS_CNT_ONE;
        s_cke_d = (s_cke_q == `DPS_CNT_SAT) ? s_cke_q : s_cke_q + `DPS_CNT_ONE;
        s_srx_d = (s_srx_q == `DPS_CNT_SAT) ? s_srx_q : s_srx_q + `DPS_CNT_ONE;
        if (pin_d == `DPS_PIN_MRS) begin
            s_mrs_d = '0;
        end
        if (cke_chg) begin
            s_cke_d = '0;
        end
        if (cke_chg && cke_d && state_q == ST_SREF) begin
            s_srx_d = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s_mrs_q <= `DPS_CNT_SAT;
            s_cke_q <= `DPS_CNT_SAT;
            s_srx_q <= `DPS_CNT_SAT;
        end else begin
            s_mrs_q <= s_mrs_d;
            s_cke_q <= s_cke_d;
            s_srx_q <= s_srx_d;
        end
    end

    property p_mrs_cke;
        @(posedge sys_clk) disable iff (!nrst)
        (cke_chg && !cke_d) |-> (s_mrs_q >= TMRS - 1);
    endproperty
    a_mrs_cke: assert property (p_mrs_cke) else $error("cke fell too soon after mrs"); // [R1]

    property p_pd_nop;
        @(posedge sys_clk) disable iff (!nrst)
        (cke_chg && state_d != ST_SREF) |=> (pin_q == `DPS_PIN_NOP);
    endproperty
    a_pd_nop: assert property (p_pd_nop) else $error("power-down edge without nop"); // [R4]

    property p_srx_nop;
        @(posedge sys_clk) disable iff (!nrst)
        ($rose(ddr_cke) && $past(state_q) == ST_SREF) |-> (pin_q == `DPS_PIN_NOP);
    endproperty
    a_srx_nop: assert property (p_srx_nop) else $error("self refresh exit without nop"); // [R5]

    property p_sre_idle;
        @(posedge sys_clk) disable iff (!nrst)
        ($fell(ddr_cke) && pin_q == `DPS_PIN_REF) |-> ($past(state_q) == ST_IDLE && !open_q);
    endproperty
    a_sre_idle: assert property (p_sre_idle) else $error("self refresh entry not from idle"); // [R6]

    property p_sre_burst;
        @(posedge sys_clk) disable iff (!nrst)
        (state_d == ST_SREF && state_q != ST_SREF) |-> !b_bst;
    endproperty
    a_sre_burst: assert property (p_sre_burst) else $error("self refresh during burst"); // [R7]

    property p_pd_max;
        @(posedge sys_clk) disable iff (!nrst)
        in_pd |-> (s_cke_q <= PDMAX - 1);
    endproperty
    a_pd_max: assert property (p_pd_max) else $error("power-down held too long"); // [R11]

    property p_cke_hold;
        @(posedge sys_clk) disable iff (!nrst)
        cke_chg |-> (s_cke_q >= TCKE - 1);
    endproperty
    a_cke_hold: assert property (p_cke_hold) else $error("cke pulse too short"); // [R12]

    property p_xs_nop;
        @(posedge sys_clk) disable iff (!nrst)
        (pin_d != `DPS_PIN_NOP) |-> (s_srx_q >= TXS - 1);
    endproperty
    a_xs_nop: assert property (p_xs_nop) else $error("command inside self refresh exit"); // [R13]

    property p_rd_dll;
        @(posedge sys_clk) disable iff (!nrst)
        (pin_d == `DPS_PIN_RD || odt_d) |-> (s_srx_d >= TXSDLL);
    endproperty
    a_rd_dll: assert property (p_rd_dll) else $error("read or odt before dll lock"); // [R13]

    property p_wr_512;
        @(posedge sys_clk) disable iff (!nrst)
        (pin_d == `DPS_PIN_WR) |-> (s_srx_q >= TWRL - 1);
    endproperty
    a_wr_512: assert property (p_wr_512) else $error("write too soon after self refresh"); // [R14]

    property p_legal;
        @(posedge sys_clk) disable iff (!nrst)
        (!ddr_cke && !$fell(ddr_cke)) |-> (pin_q == `DPS_PIN_NOP && !ddr_odt);
    endproperty
    a_legal: assert property (p_legal) else $error("command while cke low"); // [R16]

endmodule

`default_nettype wire

// ==== design/dps_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dps_defs.svh"

module dps_timer
    import dps_pkg::*;
#(
    parameter int IDX = 0
) (
    input wire logic sys_clk,
    input wire logic nrst,
    dps_tmr_if.timer t
);

    dps_cnt_type cnt_q;
    dps_cnt_type cnt_d;

    // ----------------------------------------
    // Down counter, busy while nonzero
    // ----------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        if (t.load[IDX]) begin
            cnt_d = t.val[IDX];
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - `DPS_CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign t.busy[IDX] = (cnt_q != '0);

endmodule

`default_nettype wire

// ==== inc/dps_defs.svh ====
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH

// ----------------------------------------
// Widths and timer lanes
// ----------------------------------------
`define DPS_TW 10
`define DPS_NT 7
`define DPS_T_MRS 0
`define DPS_T_CKE 1
`define DPS_T_BST 2
`define DPS_T_XS 3
`define DPS_T_DLL 4
`define DPS_T_WRL 5
`define DPS_T_PD 6
`define DPS_CNT_ONE 10'h001
`define DPS_CNT_SAT 10'h3FF

// ----------------------------------------
// Device timings in device clocks
// ----------------------------------------
`define DPS_TMRD_NCK 4
`define DPS_TMOD_NCK 12
`define DPS_TMRS_NCK ((`DPS_TMRD_NCK > `DPS_TMOD_NCK) ? `DPS_TMRD_NCK : `DPS_TMOD_NCK)
`define DPS_TCKE_NCK 3
`define DPS_TXP_NCK 3
`define DPS_TXS_NCK 64
`define DPS_TXSDLL_NCK 512
`define DPS_TWRLVL_NCK 512
`define DPS_TBURST_NCK 4
`define DPS_PD_MAX_NCK 1000

// ----------------------------------------
// Pin codes {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define DPS_PIN_MRS 4'h0
`define DPS_PIN_REF 4'h1
`define DPS_PIN_PRE 4'h2
`define DPS_PIN_ACT 4'h3
`define DPS_PIN_WR 4'h4
`define DPS_PIN_RD 4'h5
`define DPS_PIN_NOP 4'h7

`endif

// ==== inc/dps_pkg.sv ====
`include "dps_defs.svh"

package dps_pkg;

    typedef logic [`DPS_TW-1:0] dps_cnt_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ACTIVE = 3'h1,
        ST_APD = 3'h3,
        ST_PPD = 3'h2,
        ST_SREF = 3'h6
    } dps_state_type;

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_MRS = 4'h1,
        CMD_REF = 4'h2,
        CMD_ACT = 4'h3,
        CMD_PRE = 4'h4,
        CMD_RD = 4'h5,
        CMD_WR = 4'h6,
        CMD_PDE = 4'h7,
        CMD_PDX = 4'h8,
        CMD_SRE = 4'h9,
        CMD_SRX = 4'hA
    } dps_cmd_type;

endpackage

// ==== inc/dps_tmr_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dps_defs.svh"

interface dps_tmr_if;
    logic [`DPS_NT-1:0] load;
    logic [`DPS_NT-1:0][`DPS_TW-1:0] val;
    wire [`DPS_NT-1:0] busy;
    modport owner (output load, output val, input busy);
    modport timer (input load, input val, output busy);
endinterface

`default_nettype wire

// ==== test/dps_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dps_defs.svh"
// ----
// Device side of the pins
// ----
module dps_dev_model
    import dps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic odt,
    output dps_state_type dev_state,
    output logic [15:0] err_cnt
);
    logic cke_q;
    logic bank_q;
    logic bad;
    logic [3:0] cmd;
    int mrs_n, chg_n, srx_n, bst_n;
    // Deselect folds into NOP
    assign cmd = cs_n ? `DPS_PIN_NOP : {cs_n, ras_n, cas_n, we_n};
    // Termination never steers a transition
    always @(posedge sys_clk) begin
        bad = 1'b0;
        if (!nrst) begin
            cke_q <= 1'b1;
            bank_q <= 1'b0;
            dev_state <= ST_IDLE;
            err_cnt <= 16'h0000;
            mrs_n <= 9999;
            chg_n <= 9999;
            srx_n <= 9999;
            bst_n <= 9999;
        end else begin
            cke_q <= cke;
            mrs_n <= mrs_n + 1;
            chg_n <= chg_n + 1;
            srx_n <= srx_n + 1;
            bst_n <= bst_n + 1;
            if (cke !== cke_q) begin
                chg_n <= 1;
                bad = chg_n < `DPS_TCKE_NCK;
            end
            case ({cke_q, cke})
                // Pins are not looked at; only the power-down stay is timed
                2'b00: bad = (dev_state != ST_SREF) && (chg_n > `DPS_PD_MAX_NCK + 1);
                2'b01: begin
                    bad = bad | (cmd != `DPS_PIN_NOP);
                    if (dev_state == ST_SREF) srx_n <= 1;
                    dev_state <= bank_q ? ST_ACTIVE : ST_IDLE;
                end
                2'b10: begin
                    bad = bad | (mrs_n < `DPS_TMRS_NCK);
                    if (cmd == `DPS_PIN_REF) begin
                        bad = bad | bank_q | (bst_n < `DPS_TBURST_NCK) | (srx_n < `DPS_TXS_NCK);
                        dev_state <= ST_SREF;
                    end else begin
                        bad = bad | (cmd != `DPS_PIN_NOP);
                        dev_state <= bank_q ? ST_APD : ST_PPD;
                    end
                end
                default: begin
                    bad = (srx_n < `DPS_TXS_NCK) && (cmd != `DPS_PIN_NOP);
                    if (cmd == `DPS_PIN_RD) bad = bad | (srx_n < `DPS_TXSDLL_NCK) | !bank_q;
                    if (cmd == `DPS_PIN_WR) bad = bad | (srx_n < `DPS_TWRLVL_NCK) | !bank_q;
                    if (cmd == `DPS_PIN_RD || cmd == `DPS_PIN_WR) bst_n <= 1;
                    if (cmd == `DPS_PIN_MRS) mrs_n <= 1;
                    if (cmd == `DPS_PIN_ACT) begin
                        bank_q <= 1'b1;
                        dev_state <= ST_ACTIVE;
                    end
                    if (cmd == `DPS_PIN_PRE) begin
                        bank_q <= 1'b0;
                        dev_state <= ST_IDLE;
                    end
                end
            endcase
            // Termination off in self refresh and until DLL lock
            bad = bad | (odt && (dev_state == ST_SREF || srx_n < `DPS_TXSDLL_NCK));
            err_cnt <= err_cnt + {15'h0000, bad};
        end
    end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dps_defs.svh"
// ----
// Bench
// ----
module tb_top
    import dps_pkg::*;
;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    logic odt_req = 1'b0;
    dps_cmd_type req_cmd = CMD_NOP;
    logic req_ready, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_odt;
    logic exp_cke, exp_bank;
    logic [4:0] pins_w;
    logic [15:0] err_cnt;
    dps_state_type pwr_state, dev_state, st_q, exp_st;
    int num_errors = 0;
    int checks = 0;
    int seed = 32'h5775;
    int cyc = 0;
    int t0, t1;
    assign pins_w = {ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    // Device acts one edge after the controller
    always @(posedge sys_clk) st_q <= pwr_state;
    dps_ctrl dut_u (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_ready(req_ready), .odt_req(odt_req), .pwr_state(pwr_state), .ddr_cke(ddr_cke),
        .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n),
        .ddr_we_n(ddr_we_n), .ddr_odt(ddr_odt));
    dps_dev_model dev_u (.sys_clk(sys_clk), .nrst(nrst), .cke(ddr_cke), .cs_n(ddr_cs_n),
        .ras_n(ddr_ras_n), .cas_n(ddr_cas_n), .we_n(ddr_we_n), .odt(ddr_odt),
        .dev_state(dev_state), .err_cnt(err_cnt));
    task automatic fail(input string m);
        num_errors++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task automatic chk_st(input dps_state_type e, input dps_state_type g);
        checks++;
        if (g !== e) fail("state");
    endtask
    task automatic chk_bits(input logic [4:0] e, input logic [4:0] g);
        checks++;
        if (g !== e) fail("pins");
    endtask
    task automatic chk_true(input logic ok);
        checks++;
        if (ok !== 1'b1) fail("spacing");
    endtask
    function automatic dps_state_type nxt(dps_state_type s, dps_cmd_type c, logic b);
        case (c)
            CMD_MRS, CMD_REF, CMD_PRE, CMD_SRX: return ST_IDLE;
            CMD_ACT, CMD_RD, CMD_WR: return ST_ACTIVE;
            CMD_PDE: return b ? ST_APD : ST_PPD;
            CMD_PDX: return b ? ST_ACTIVE : ST_IDLE;
            CMD_SRE: return ST_SREF;
            default: return s;
        endcase
    endfunction
    function automatic logic [3:0] pin_of(dps_cmd_type c);
        case (c)
            CMD_MRS: return `DPS_PIN_MRS;
            CMD_REF, CMD_SRE: return `DPS_PIN_REF;
            CMD_ACT: return `DPS_PIN_ACT;
            CMD_PRE: return `DPS_PIN_PRE;
            CMD_RD: return `DPS_PIN_RD;
            CMD_WR: return `DPS_PIN_WR;
            default: return `DPS_PIN_NOP;
        endcase
    endfunction
    // Only requests that become legal in time, so a held request never hangs
    function automatic dps_cmd_type pick(dps_state_type s, int unsigned r);
        dps_cmd_type ic[7] = '{CMD_NOP, CMD_MRS, CMD_REF, CMD_ACT, CMD_PRE, CMD_PDE, CMD_SRE};
        dps_cmd_type ac[6] = '{CMD_NOP, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR, CMD_PDE};
        case (s)
            ST_IDLE: return ic[r % 7];
            ST_ACTIVE: return ac[r % 6];
            ST_SREF: return CMD_SRX;
            default: return CMD_PDX;
        endcase
    endfunction
    task automatic do_req(input dps_cmd_type c, output int t);
        int n;
        n = 0;
        req_cmd = c;
        req_valid = 1'b1;
        odt_req = 1'($random(seed));
        @(negedge sys_clk);
        while (req_ready !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 2000) fail("no ready");
        @(posedge sys_clk);
        t = cyc;
        #1;
        exp_st = nxt(exp_st, c, exp_bank);
        if (c == CMD_ACT) exp_bank = 1'b1;
        if (c == CMD_PRE) exp_bank = 1'b0;
        if (c == CMD_PDE || c == CMD_SRE) exp_cke = 1'b0;
        if (c == CMD_PDX || c == CMD_SRX) exp_cke = 1'b1;
        chk_st(exp_st, pwr_state);
        chk_bits({exp_cke, pin_of(c)}, pins_w);
    endtask
    task automatic idle(input int n);
        req_valid = 1'b0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(negedge sys_clk) begin
        if (nrst) begin
            chk_st(st_q, dev_state);
            if (pwr_state === ST_SREF) chk_bits(5'h00, {4'h0, ddr_odt});
        end
    end
    initial begin
        // Several times the longest expected run, still short of the cycle budget
        #500000;
        fail("watchdog");
        end_sim;
    end
    initial begin
        exp_st = ST_IDLE;
        exp_cke = 1'b1;
        exp_bank = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        do_req(CMD_MRS, t0);
        do_req(CMD_PDE, t1);
        chk_true(t1 - t0 >= `DPS_TMRS_NCK);
        do_req(CMD_PDX, t0);
        chk_true(t0 - t1 >= `DPS_TCKE_NCK);
        $display("test mrs_pd done");
        do_req(CMD_ACT, t0);
        do_req(CMD_RD, t0);
        do_req(CMD_PDE, t1);
        chk_true(t1 - t0 >= `DPS_TBURST_NCK);
        do_req(CMD_PDX, t0);
        do_req(CMD_PRE, t0);
        $display("test apd done");
        do_req(CMD_SRE, t1);
        do_req(CMD_SRX, t0);
        chk_true(t0 - t1 >= `DPS_TCKE_NCK);
        do_req(CMD_ACT, t1);
        chk_true(t1 - t0 >= `DPS_TXS_NCK);
        do_req(CMD_WR, t1);
        chk_true(t1 - t0 >= `DPS_TWRLVL_NCK);
        do_req(CMD_RD, t1);
        chk_true(t1 - t0 >= `DPS_TXSDLL_NCK);
        do_req(CMD_PRE, t0);
        $display("test sref done");
        do_req(CMD_PDE, t0);
        idle(`DPS_PD_MAX_NCK - 10);
        chk_bits({1'b0, `DPS_PIN_NOP}, pins_w);
        idle(15);
        exp_cke = 1'b1;
        exp_st = ST_IDLE;
        chk_bits({1'b1, `DPS_PIN_NOP}, pins_w);
        chk_st(exp_st, pwr_state);
        $display("test forced exit done");
        repeat (150) do_req(pick(exp_st, $unsigned($random(seed))), t0);
        idle(20);
        chk_true(err_cnt === 16'h0000);
        $display("test random done");
        nrst = 1'b0;
        idle(3);
        nrst = 1'b1;
        exp_st = ST_IDLE;
        exp_cke = 1'b1;
        exp_bank = 1'b0;
        idle(1);
        chk_st(exp_st, pwr_state);
        chk_bits({1'b1, `DPS_PIN_NOP}, pins_w);
        $display("test reset done");
        end_sim;
    end
endmodule
`default_nettype wire
